// ### design/sbs_stop_sequencer.v
// Stop, brake and direction sequencer with a Wishbone register file.
// Assumes an external ramp generator that reports its output frequency
// and a power stage that obeys the enable and brake outputs.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "sbs_defines.vh"

module sbs_stop_sequencer
#(
   parameter [19:0] TICK_CYC = `SBS_TICK_CYC
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Terminal pins, asynchronous
   input  wire        term_run_pin,
   input  wire        term_reverse_pin,
   input  wire        power_ok_pin,
   input  wire        estop_pin,
   // Frequencies from the control loop, 0.01 Hz units
   input  wire [15:0] set_freq,
   input  wire [15:0] fb_freq,
   input  wire [15:0] run_freq,
   input  wire [15:0] low_limit_freq,
   input  wire [15:0] start_freq,
   // Commands to ramp generator and power stage
   output reg         drive_enable_o,
   output reg         decel_request_o,
   output reg         emerg_decel_o,
   output reg  [15:0] emerg_decel_time_o,
   output reg  [15:0] scurve_start_o,
   output reg  [15:0] scurve_end_o,
   output reg         hold_low_limit_o,
   output reg         reverse_o,
   output reg  [1:0]  brake_mode_o,
   output reg  [15:0] brake_current_o,
   // Status
   output reg         sleeping_o,
   output reg         stopped_o
);

   localparam [3:0] S_IDLE    = 4'h0;
   localparam [3:0] S_START   = 4'h1;
   localparam [3:0] S_RUN     = 4'h2;
   localparam [3:0] S_DECEL   = 4'h3;
   localparam [3:0] S_SHORT   = 4'h4;
   localparam [3:0] S_DEMAG   = 4'h5;
   localparam [3:0] S_DCBRK   = 4'h6;
   localparam [3:0] S_REVDEC  = 4'h7;
   localparam [3:0] S_REVDLY  = 4'h8;
   localparam [3:0] S_DEAD    = 4'h9;
   localparam [3:0] S_SLEEP   = 4'ha;
   localparam [3:0] S_WAKE    = 4'hb;
   localparam [3:0] S_RESTART = 4'hc;

   localparam [1:0] BRK_NONE  = 2'h0;
   localparam [1:0] BRK_DC    = 2'h1;
   localparam [1:0] BRK_SHORT = 2'h2;

   localparam [19:0] TICK_LAST = TICK_CYC - 20'h00001;

   // Setting in 10 ms or 100 ms units converted to ticks
   function [19:0] to_ticks;
      input [15:0] v;
      input        tenth;
      begin
         if (tenth)
            to_ticks = {1'b0, v, 3'b000} + {3'b000, v, 1'b0};
         else
            to_ticks = {4'h0, v};
      end
   endfunction

   function [15:0] reset_val;
      input [4:0] idx;
      begin
         if (idx == `SBS_IDX_SW_MODE)
            reset_val = `SBS_RST_SW_MODE;
         else if (idx == `SBS_IDX_HALT_SPD)
            reset_val = `SBS_RST_HALT_SPD;
         else if (idx == `SBS_IDX_HALT_SRC)
            reset_val = `SBS_RST_HALT_SRC;
         else if (idx == `SBS_IDX_RST_WAIT)
            reset_val = `SBS_RST_RST_WAIT;
         else if (idx == `SBS_IDX_EMERG_DEC)
            reset_val = `SBS_RST_EMERG_DEC;
         else if (idx == `SBS_IDX_SC_START || idx == `SBS_IDX_SC_END)
            reset_val = `SBS_RST_SC_TIME;
         else
            reset_val = 16'h0000;
      end
   endfunction

   // ---------------- Register file ----------------
   reg  [15:0] regs_q [0:`SBS_NREG-1];
   wire [4:0]  idx      = wb_adr_i[6:2];
   wire        req      = wb_cyc_i & wb_stb_i;
   wire        in_map   = ~wb_adr_i[7] & (idx < 5'd23);
   wire        wr_now   = req & wb_ack_o & wb_we_i & in_map;
   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg         armed_q;
   reg         halt_det;
   reg  [15:0] status;
   integer     i;
   integer     j;

   always @*
   begin
      status = {8'h00, state_q, armed_q, halt_det, reverse_o, sleeping_o};
   end

   // Ack one cycle after the request; the write lands on the edge that
   // the master samples ack, so a request dropped after its ack writes exactly once.
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o)
         begin
            if (idx == `SBS_IDX_STATUS && ~wb_adr_i[7])
               wb_dat_o <= {16'h0000, status};
            else if (in_map)
               wb_dat_o <= {16'h0000, regs_q[idx]};
            else
               wb_dat_o <= 32'h00000000;
         end
      end
   end

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (i = 0; i < `SBS_NREG; i = i + 1)
            regs_q[i] <= reset_val(i[4:0]);
      end
      else if (wr_now && idx != `SBS_IDX_STATUS)
      begin
         if (wb_sel_i[0])
            regs_q[idx][7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1])
            regs_q[idx][15:8] <= wb_dat_i[15:8];
      end
   end

   wire [15:0] r_brk_freq  = regs_q[`SBS_IDX_BRK_FREQ];
   wire [15:0] r_demag     = regs_q[`SBS_IDX_DEMAG];
   wire [15:0] r_brk_cur   = regs_q[`SBS_IDX_BRK_CUR];
   wire [15:0] r_brk_dur   = regs_q[`SBS_IDX_BRK_DUR];
   wire [15:0] r_deadzone  = regs_q[`SBS_IDX_DEADZONE];
   wire [1:0]  r_sw_mode   = regs_q[`SBS_IDX_SW_MODE][1:0];
   wire [15:0] r_halt_spd  = regs_q[`SBS_IDX_HALT_SPD];
   wire        r_halt_src  = regs_q[`SBS_IDX_HALT_SRC][0];
   wire [15:0] r_halt_chk  = regs_q[`SBS_IDX_HALT_CHK];
   wire        r_guard     = regs_q[`SBS_IDX_GUARD][0];
   wire [3:0]  r_ll_ones   = regs_q[`SBS_IDX_LOW_ACT][3:0];
   wire [3:0]  r_ll_tens   = regs_q[`SBS_IDX_LOW_ACT][7:4];
   wire [15:0] r_wake      = regs_q[`SBS_IDX_WAKE];
   wire        r_rst_en    = regs_q[`SBS_IDX_RST_EN][0];
   wire [15:0] r_rst_wait  = regs_q[`SBS_IDX_RST_WAIT];
   wire [15:0] r_start_dly = regs_q[`SBS_IDX_START_DLY];
   wire [15:0] r_halt_dly  = regs_q[`SBS_IDX_HALT_DLY];
   wire [1:0]  r_zero_mode = regs_q[`SBS_IDX_ZERO_MODE][1:0];
   wire [15:0] r_short_cur = regs_q[`SBS_IDX_SHORT_CUR];
   wire [15:0] r_short_hld = regs_q[`SBS_IDX_SHORT_HOLD];
   wire [15:0] r_ctrl      = regs_q[`SBS_IDX_CTRL];

   // ---------------- Pin synchronisers ----------------
   // Three stages; a level is accepted only when stages two and three
   // agree, which also rejects a single-cycle glitch.
   reg [3:0] sync1_q;
   reg [3:0] sync2_q;
   reg [3:0] sync3_q;
   reg [3:0] pins_q;

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         sync3_q <= 4'h0;
         pins_q  <= 4'h0;
      end
      else
      begin
         sync1_q <= {estop_pin, power_ok_pin, term_reverse_pin, term_run_pin};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (j = 0; j < 4; j = j + 1)
            if (sync2_q[j] == sync3_q[j])
               pins_q[j] <= sync3_q[j];
      end
   end

   wire run_pin  = pins_q[0];
   wire rev_pin  = pins_q[1];
   wire power_ok = pins_q[2];
   wire estop    = pins_q[3];

   // ---------------- Time base ----------------
   reg  [19:0] pre_q;
   reg  [19:0] tmr_q;
   reg  [19:0] tmr_d;
   reg  [15:0] hcnt_q;
   wire        tick     = (pre_q == TICK_LAST);
   wire        tmr_done = (tmr_q == 20'h00000);

   always @(posedge clk or posedge reset)
   begin
      if (reset)
         pre_q <= 20'h00000;
      else if (tick)
         pre_q <= 20'h00000;
      else
         pre_q <= pre_q + 20'h00001;
   end

   // ---------------- Halt speed detection ----------------
   wire [15:0] halt_src_spd = (~r_halt_src && r_ctrl[`SBS_CTRL_VVC]) ?
                              set_freq : fb_freq;
   wire        below_halt   = (halt_src_spd < r_halt_spd);

   always @(posedge clk or posedge reset)
   begin
      if (reset)
         hcnt_q <= 16'h0000;
      else if (!below_halt)
         hcnt_q <= 16'h0000;
      else if (tick && hcnt_q != 16'hffff)
         hcnt_q <= hcnt_q + 16'h0001;
   end

   always @*
   begin
      halt_det = below_halt && (hcnt_q >= r_halt_chk);
   end

   // ---------------- Sequencer ----------------
   reg        sleep_pend_q;
   reg        sleep_pend_d;
   reg        emerg_q;
   reg        emerg_d;
   reg        restart_pend_q;
   reg        reverse_d;
   reg        low_q;

   wire low_active = (low_limit_freq != 16'h0000) && (set_freq < low_limit_freq);
   wire ll_stop    = low_active && (r_ll_ones == 4'h1);
   wire ll_sleep   = low_active && (r_ll_ones == 4'h2);
   wire run_ok     = armed_q && run_pin && power_ok;
   wire rev_want   = rev_pin != reverse_o;
   // Halt speed opens braking too, so a zero brake frequency cannot hang
   wire brk_zone   = (run_freq < r_brk_freq) || halt_det;
   wire stop_end   = (r_brk_dur == 16'h0000) ? halt_det : 1'b0;
   wire [3:0] stop_tail = sleep_pend_q ? S_SLEEP : S_IDLE;

   reg  rev_point;
   always @*
   begin
      case (r_sw_mode)
         2'h0:    rev_point = (run_freq == 16'h0000);
         2'h1:    rev_point = (run_freq <= start_freq);
         default: rev_point = halt_det;
      endcase
   end

   always @*
   begin
      state_d      = state_q;
      tmr_d        = (tick && !tmr_done) ? tmr_q - 20'h00001 : tmr_q;
      sleep_pend_d = sleep_pend_q;
      emerg_d      = emerg_q;
      reverse_d    = reverse_o;
      case (state_q)
         S_IDLE:
         begin
            sleep_pend_d = 1'b0;
            emerg_d      = 1'b0;
            if (restart_pend_q && power_ok && run_pin)
            begin
               state_d = S_RESTART;
               tmr_d   = to_ticks(r_rst_wait, 1'b1);
            end
            else if (run_ok && !ll_stop && !ll_sleep)
            begin
               state_d   = S_START;
               reverse_d = rev_pin;
               tmr_d     = to_ticks(r_start_dly, 1'b1);
            end
         end
         S_RESTART, S_START, S_WAKE:
            if (tmr_done)
               state_d = S_RUN;
         S_RUN:
            if (estop)
            begin
               state_d = S_DECEL;
               emerg_d = 1'b1;
            end
            else if (!run_ok || ll_stop || ll_sleep)
            begin
               sleep_pend_d = ll_sleep && run_ok;
               if ((run_ok && r_ll_tens == 4'h0) ||
                   (!run_ok && r_ctrl[`SBS_CTRL_COAST]))
                  state_d = ll_sleep && run_ok ? S_SLEEP : S_IDLE;
               else
                  state_d = S_DECEL;
            end
            else if (rev_want)
               state_d = S_REVDEC;
         S_DECEL:
            // Braking is entered from the ramp only, never skipped ahead
            if (r_brk_dur != 16'h0000 && brk_zone)
            begin
               if (r_short_hld != 16'h0000)
               begin
                  state_d = S_SHORT;
                  tmr_d   = to_ticks(r_short_hld, 1'b0);
               end
               else
               begin
                  state_d = S_DEMAG;
                  tmr_d   = to_ticks(r_demag, 1'b0);
               end
            end
            else if (stop_end)
               state_d = stop_tail;
         S_SHORT:
            if (tmr_done)
            begin
               state_d = S_DEMAG;
               tmr_d   = to_ticks(r_demag, 1'b0);
            end
         S_DEMAG:
            if (tmr_done)
            begin
               state_d = S_DCBRK;
               tmr_d   = to_ticks(r_brk_dur, 1'b0);
            end
         S_DCBRK:
            if (tmr_done)
               state_d = stop_tail;
         S_REVDEC:
            if (!run_ok || estop)
               state_d = S_RUN;
            else if (rev_point)
            begin
               state_d = (r_sw_mode == 2'h2) ? S_REVDLY : S_DEAD;
               tmr_d   = (r_sw_mode == 2'h2) ? to_ticks(r_halt_dly, 1'b1) :
                         to_ticks(r_deadzone, 1'b1);
            end
         S_REVDLY:
            if (tmr_done)
            begin
               state_d = S_DEAD;
               tmr_d   = to_ticks(r_deadzone, 1'b1);
            end
         S_DEAD:
            if (tmr_done)
            begin
               state_d   = S_RUN;
               reverse_d = rev_pin;
            end
         S_SLEEP:
            if (!run_ok)
               state_d = S_IDLE;
            else if (!low_active)
            begin
               state_d = S_WAKE;
               tmr_d   = to_ticks(r_wake, 1'b1);
            end
         default:
            state_d = S_IDLE;
      endcase
      // Loss of mains overrides everything: the stage has no bus to run on
      if (!power_ok)
         state_d = S_IDLE;
   end

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_q        <= S_IDLE;
         tmr_q          <= 20'h00000;
         sleep_pend_q   <= 1'b0;
         emerg_q        <= 1'b0;
         reverse_o      <= 1'b0;
         armed_q        <= 1'b0;
         restart_pend_q <= 1'b0;
         low_q          <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         tmr_q        <= tmr_d;
         sleep_pend_q <= sleep_pend_d;
         emerg_q      <= emerg_d;
         reverse_o    <= reverse_d;
         low_q        <= power_ok;
         // A run level present since power-up is honoured only with the guard
         // on; otherwise the terminal must drop once before it counts.
         if (!power_ok && !r_rst_en)
            armed_q <= 1'b0;
         else if (!run_pin || r_guard)
            armed_q <= 1'b1;
         if (low_q && !power_ok && r_rst_en && state_q != S_IDLE)
            restart_pend_q <= 1'b1;
         else if (!r_rst_en || state_q == S_RESTART || (power_ok && !run_pin))
            restart_pend_q <= 1'b0;
      end
   end

   // ---------------- Output decode, registered ----------------
   reg        en_d;
   reg [1:0]  bm_d;
   reg [15:0] bc_d;

   always @*
   begin
      en_d = 1'b0;
      bm_d = BRK_NONE;
      bc_d = 16'h0000;
      case (state_q)
         S_RUN, S_REVDEC, S_REVDLY, S_DEAD, S_DECEL:
         begin
            en_d = 1'b1;
            // Keyed to the commanded frequency: the ramp output is zero at
            // every start, and gating on it would never let the ramp leave 0
            if (state_q == S_RUN && set_freq == 16'h0000)
            begin
               case (r_zero_mode)
                  2'h0:    en_d = 1'b0;
                  2'h2:
                  begin
                     bm_d = BRK_DC;
                     bc_d = r_brk_cur;
                  end
                  default: en_d = 1'b1;
               endcase
            end
         end
         S_SHORT:
         begin
            bm_d = BRK_SHORT;
            bc_d = r_short_cur;
         end
         S_DCBRK:
         begin
            bm_d = BRK_DC;
            bc_d = r_brk_cur;
         end
         default:
            en_d = 1'b0;
      endcase
   end

   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         drive_enable_o     <= 1'b0;
         decel_request_o    <= 1'b0;
         emerg_decel_o      <= 1'b0;
         emerg_decel_time_o <= `SBS_RST_EMERG_DEC;
         scurve_start_o     <= `SBS_RST_SC_TIME;
         scurve_end_o       <= `SBS_RST_SC_TIME;
         hold_low_limit_o   <= 1'b0;
         brake_mode_o       <= BRK_NONE;
         brake_current_o    <= 16'h0000;
         sleeping_o         <= 1'b0;
         stopped_o          <= 1'b1;
      end
      else
      begin
         drive_enable_o     <= en_d;
         decel_request_o    <= (state_q == S_DECEL) || (state_q == S_REVDEC);
         emerg_decel_o      <= emerg_q && state_q == S_DECEL;
         emerg_decel_time_o <= regs_q[`SBS_IDX_EMERG_DEC];
         scurve_start_o     <= regs_q[`SBS_IDX_SC_START];
         scurve_end_o       <= regs_q[`SBS_IDX_SC_END];
         hold_low_limit_o   <= low_active && r_ll_ones == 4'h0 &&
                               state_q == S_RUN;
         brake_mode_o       <= bm_d;
         brake_current_o    <= bc_d;
         sleeping_o         <= (state_q == S_SLEEP);
         stopped_o          <= (state_q == S_IDLE) || (state_q == S_SLEEP);
      end
   end

endmodule
`default_nettype wire

// ### design/sbs_defines.vh
// Constants for the stop and brake sequencer: register indices, reset
// values and time base. Assumes a 50 MHz clock and a Wishbone word bus.
// Notes on behaviour
// - Stop mode 1 cuts output, load coasts.
// - Wait demagnetize time before stop braking.
// - Stop brake current programmable, default zero.
// - Hold brake set time; zero disables it.
// - Insert deadzone time at direction change.
// - Switch direction at zero, start, stop-speed.
// - Stopped once speed below halt speed.
// - Compare set or feedback speed by source; feedback always with VVC off.
// - Halt check time qualifies the stop speed.
// - Guard off ignores run held at power-up.
// - Below lower limit: run, stop or sleep.
// - Tens digit picks coast or decelerate stop.
// - Wake delay applies only in sleep action.
// - Auto restart resumes run after power returns.
// - Restart wait counts only when enabled.
// - Zero frequency: off, voltage or brake current.
// - Emergency stop uses its own decel time.
// - Short-circuit brake current programmable.
// - Stop mode 0 ramps down to halt speed.
// - Short brake first, then DC brake.
`ifndef SBS_DEFINES_VH
`define SBS_DEFINES_VH

// Register indices; byte address is four times the index
`define SBS_IDX_BRK_FREQ     5'h00
`define SBS_IDX_DEMAG        5'h01
`define SBS_IDX_BRK_CUR      5'h02
`define SBS_IDX_BRK_DUR      5'h03
`define SBS_IDX_DEADZONE     5'h04
`define SBS_IDX_SW_MODE      5'h05
`define SBS_IDX_HALT_SPD     5'h06
`define SBS_IDX_HALT_SRC     5'h07
`define SBS_IDX_HALT_CHK     5'h08
`define SBS_IDX_GUARD        5'h09
`define SBS_IDX_LOW_ACT      5'h0a
`define SBS_IDX_WAKE         5'h0b
`define SBS_IDX_RST_EN       5'h0c
`define SBS_IDX_RST_WAIT     5'h0d
`define SBS_IDX_START_DLY    5'h0e
`define SBS_IDX_HALT_DLY     5'h0f
`define SBS_IDX_ZERO_MODE    5'h10
`define SBS_IDX_EMERG_DEC    5'h11
`define SBS_IDX_SC_START     5'h12
`define SBS_IDX_SC_END       5'h13
`define SBS_IDX_SHORT_CUR    5'h14
`define SBS_IDX_SHORT_HOLD   5'h15
`define SBS_IDX_CTRL         5'h16
`define SBS_IDX_STATUS       5'h17
`define SBS_NREG             23

// Control register fields
`define SBS_CTRL_COAST       0
`define SBS_CTRL_VVC         1

// Non-zero reset values (all others reset to zero)
`define SBS_RST_SW_MODE      16'h0001
`define SBS_RST_HALT_SPD     16'h0032
`define SBS_RST_HALT_SRC     16'h0001
`define SBS_RST_RST_WAIT     16'h000a
`define SBS_RST_EMERG_DEC    16'h0014
`define SBS_RST_SC_TIME      16'h0001

// Time base: one tick is 10 ms, the finest unit of any time setting
`define SBS_TICK_MS          10
`define SBS_CLK_KHZ          50000
`define SBS_TICK_CYC         20'h7a120

`endif

// ### verif/sbs_motor_model.sv
// Motor and ramp model: speed rises while driven, falls otherwise.
// Assumes 0.01 Hz units and one clock shared with the sequencer.
`timescale 1ns/100ps
`default_nettype none
module sbs_motor_model
(
   // Clock
   input  wire logic        clk,
   // Commands from the sequencer
   input  wire logic        drive_enable_o,
   input  wire logic        decel_request_o,
   // Speed seen by the sequencer
   output var  logic [15:0] fb_freq,
   output var  logic [15:0] run_freq
);
   initial run_freq = 16'h0000;
   assign fb_freq = run_freq;
   // Coasting sheds speed slower than a commanded ramp-down
   always @(posedge clk)
      if (drive_enable_o && !decel_request_o)
         run_freq <= (run_freq > 16'd4975) ? 16'd5000 : run_freq + 16'd25;
      else
         run_freq <= (run_freq < 16'd25) ? 16'd0 : run_freq - (drive_enable_o ? 16'd25 : 16'd10);
endmodule
`default_nettype wire

// ### verif/sbs_stop_sequencer_sva.sv
// Property checker for the stop and brake sequencer.
// Assumes it sees only the top ports; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module sbs_stop_sequencer_sva
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Sequencer outputs
   input wire logic        drive_enable_o,
   input wire logic        decel_request_o,
   input wire logic        hold_low_limit_o,
   input wire logic [1:0]  brake_mode_o,
   input wire logic        sleeping_o,
   input wire logic        stopped_o
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not answered next cycle");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_read_upper;
      wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000;
   endproperty
   a_read_upper: assert property (p_read_upper)
      else $error("read data upper half not zero");
   property p_brake_entry;
      brake_mode_o == 2'd1 && $past(brake_mode_o) != 2'd1 |-> !$past(drive_enable_o);
   endproperty
   a_brake_entry: assert property (p_brake_entry)
      else $error("braking began without output off first");
   property p_brake_exit;
      brake_mode_o == 2'd1 ##1 brake_mode_o != 2'd1 |-> stopped_o;
   endproperty
   a_brake_exit: assert property (p_brake_exit)
      else $error("braking ended elsewhere than stopped");
   property p_stop_no_ramp;
      stopped_o |-> !decel_request_o;
   endproperty
   a_stop_no_ramp: assert property (p_stop_no_ramp)
      else $error("ramp-down while stopped");
   property p_hold_runs;
      hold_low_limit_o |-> !stopped_o && !sleeping_o;
   endproperty
   a_hold_runs: assert property (p_hold_runs)
      else $error("low-limit hold while stopped");
   property p_sleep_stopped;
      sleeping_o |-> stopped_o && !drive_enable_o;
   endproperty
   a_sleep_stopped: assert property (p_sleep_stopped)
      else $error("sleep without stopped");
endmodule
bind sbs_stop_sequencer sbs_stop_sequencer_sva u_sva (.clk, .reset, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_ack_o, .wb_dat_o, .drive_enable_o, .decel_request_o, .hold_low_limit_o,
   .brake_mode_o, .sleeping_o, .stopped_o);
`default_nettype wire

// ### verif/sbs_stop_sequencer_bench.sv
// Self-checking bench for the stop and brake sequencer.
// Assumes the motor model feeds the speed inputs back.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   $display("unexpected %s exp %h got %h", nm, e, g); mismatches++; end end
`define WAITC(c) begin w = 0; while (!(c) && w < 3000) begin @(posedge clk); w++; end end
module sbs_stop_sequencer_bench;
   logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        term_run_pin, term_reverse_pin, power_ok_pin, estop_pin;
   logic        drive_enable_o, decel_request_o, emerg_decel_o, hold_low_limit_o;
   logic        reverse_o, sleeping_o, stopped_o;
   logic [1:0]  brake_mode_o;
   logic [3:0]  wb_sel_i;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, e;
   logic [15:0] set_freq, fb_freq, run_freq, low_limit_freq, start_freq, v;
   logic [15:0] emerg_decel_time_o, scurve_start_o, scurve_end_o, brake_current_o;
   logic [31:0] exp_q[$];
   int          mismatches, tests_run, w, n, i, cycles;
   sbs_stop_sequencer #(.TICK_CYC(20'd20)) u_dut (.*);
   sbs_motor_model u_motor (.*);
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task give_verdict;
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task bus(input [7:0] a, input wr, input [15:0] d, input [3:0] s);
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, wr};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, 16'h0000, d};
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task rd(input [7:0] a, input [15:0] x);
      exp_q.push_back({16'h0000, x});
      bus(a, 1'b0, 16'h0000, 4'h3);
   endtask
   function [15:0] rst_val(input [4:0] k);
      case (k)
         5'h05, 5'h07, 5'h12, 5'h13: rst_val = 16'h0001;
         5'h06: rst_val = 16'h0032;
         5'h0d: rst_val = 16'h000a;
         5'h11: rst_val = 16'h0014;
         default: rst_val = 16'h0000;
      endcase
   endfunction
   // Reads are compared in order of issue when their ack appears
   always @(posedge clk)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      begin
         e = exp_q.pop_front();
         `CHK("read data", e, wb_dat_o)
      end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         give_verdict;
      end
   end
   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {term_run_pin, term_reverse_pin, power_ok_pin, estop_pin} = 4'b1010;
      {set_freq, low_limit_freq, start_freq} = {16'd5000, 16'h0000, 16'h0032};
      reset = 1'b1;
      v = 16'($urandom(32'h6266df2b));
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      for (i = 0; i < 23; i++)
         rd(8'(i * 4), rst_val(i[4:0]));
      bus(8'h80, 1'b1, 16'hffff, 4'h3);
      rd(8'h80, 16'h0000);
      `CHK("emergency time", 16'h0014, emerg_decel_time_o)
      `CHK("s-curve start", 16'h0001, scurve_start_o)
      for (i = 0; i < 4; i++)
      begin
         v = 16'($urandom);
         bus(8'h4c, 1'b1, v, 4'h3);
         rd(8'h4c, v);
         `CHK("s-curve end", v, scurve_end_o)
      end
      bus(8'h50, 1'b1, 16'hffff, 4'h1);
      rd(8'h50, 16'h00ff);
      `CHK("stopped", 1'b1, stopped_o)
      `CHK("enable", 1'b0, drive_enable_o)
      bus(8'h00, 1'b1, 16'h1000, 4'h3);
      bus(8'h04, 1'b1, 16'h0001, 4'h3);
      bus(8'h08, 1'b1, 16'h0123, 4'h3);
      bus(8'h0c, 1'b1, 16'h0002, 4'h3);
      term_run_pin <= 1'b0;
      repeat (8) @(posedge clk);
      term_run_pin <= 1'b1;
      `WAITC(drive_enable_o === 1'b1)
      `CHK("enable", 1'b1, drive_enable_o)
      `WAITC(run_freq >= 16'd4500)
      term_run_pin <= 1'b0;
      `WAITC(decel_request_o === 1'b1)
      `CHK("ramp down", 1'b1, decel_request_o)
      `WAITC(brake_mode_o === 2'd1)
      `CHK("brake current", 16'h0123, brake_current_o)
      n = 0;
      while (brake_mode_o === 2'd1 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("brake length", 1'b1, n >= 38 && n <= 46)
      repeat (3) @(posedge clk);
      `CHK("stopped", 1'b1, stopped_o)
      bus(8'h58, 1'b1, 16'h0001, 4'h3);
      term_run_pin <= 1'b1;
      `WAITC(drive_enable_o === 1'b1)
      repeat (50) @(posedge clk);
      term_run_pin <= 1'b0;
      n = 0;
      while (drive_enable_o === 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("coast delay", 1'b1, n < 12)
      `CHK("ramp down", 1'b0, decel_request_o)
      `WAITC(stopped_o === 1'b1)
      bus(8'h58, 1'b1, 16'h0000, 4'h3);
      bus(8'h0c, 1'b1, 16'h0000, 4'h3);
      term_run_pin <= 1'b1;
      `WAITC(drive_enable_o === 1'b1)
      {set_freq, low_limit_freq} <= {16'd10, 16'd100};
      `WAITC(hold_low_limit_o === 1'b1)
      `CHK("low hold", 1'b1, hold_low_limit_o)
      bus(8'h28, 1'b1, 16'h0012, 4'h3);
      `WAITC(sleeping_o === 1'b1)
      `CHK("sleep", 1'b1, sleeping_o)
      `CHK("low hold", 1'b0, hold_low_limit_o)
      {set_freq, low_limit_freq} <= {16'd5000, 16'h0000};
      `WAITC(drive_enable_o === 1'b1)
      `CHK("wake", 1'b1, drive_enable_o)
      estop_pin <= 1'b1;
      `WAITC(emerg_decel_o === 1'b1)
      `CHK("emergency", 1'b1, emerg_decel_o)
      give_verdict;
   end
endmodule
`default_nettype wire
